// ===== pkg/vpwc_pkg.sv
// Package with timing, mode and state definitions for the VPW link controller
// Function
// R1: Receive line always observed, asleep or awake
// R2: Messages still decoded while wake low
// R3: Device never self-wakes; controller raises wake
// R4: Overtemperature latches driver off
// R5: Latch cleared by transmit low-to-high toggle
// R6: Clear works only after cooling hysteresis
// R7: Pulse timer restarts on every receive edge
// R8: Frame starts with long high symbol
// R9: Short versus long pulse gives bit value
// R10: Data ends with long low symbol
// R11: Arbitrate only after inter-message idle window
// R12: Longest zero run wins; losers stop sending
// R13: Supply loss disables bus output stage
// R14: Ground loss stops sourcing, opens ground switch
// R15: Transmit low releases bus, high drives
// R16: Mode select picks shaped, fast, loopback
// R17: Loopback echoes transmit, bus untouched
// R18: Transmitter enabled only while wake high
// R19: Symbol timing by clock tick counter
// R20: Fault conditions visible as status flags
package vpwc_pkg;
  localparam int CLK_MHZ      = 125;
  localparam int TICKS_PER_US = CLK_MHZ;
  localparam int SOF_US       = 200;
  localparam int EOD_US       = 200;
  localparam int THRESH_US    = 96;
  localparam int SHORT_US     = 64;
  localparam int LONG_US      = 128;
  localparam int IDLE_MIN_US  = 280;
  localparam int SOF_MIN_US   = 163;
  localparam int US_W         = 10;
  localparam int PRESC_W      = 8;
  localparam logic [US_W-1:0] US_ZERO = 10'h000;
  localparam logic [1:0] MODE_SHAPED = 2'h0;
  localparam logic [1:0] MODE_FAST   = 2'h1;
  localparam logic [1:0] MODE_LOOP   = 2'h2;
  localparam int FIFO_DEPTH   = 32;
  typedef enum {TX_IDLE, TX_WAIT, TX_SOF, TX_BIT, TX_EOD, TX_RECOVER} vpwc_tx_e;
endpackage

// ===== rtl/vpwc_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module vpwc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock, enable, reset
  input  wire logic             CORE_CLK,
  input  wire logic             CE,
  input  wire logic             RST_N,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // Honest full and empty from the occupancy count
  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rp_r];

  // Storage writes need no reset
  always_ff @(posedge CORE_CLK) begin
    if (CE && push) begin
      mem[wp_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (CE) begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ===== rtl/vpwc_ctrl.sv
// Host-side controller that drives a VPW bus transceiver through its pins
`timescale 1ns/1ps
module vpwc_ctrl
  import vpwc_pkg::*;
#(
  parameter int TICKS_US = vpwc_pkg::TICKS_PER_US
) (
  // Clock, enable, reset
  input  wire logic       CORE_CLK,
  input  wire logic       CE,
  input  wire logic       RST_N,
  // User transmit stream, one bit per word
  input  wire logic       TX_BIT_IN,
  input  wire logic       TX_LAST_IN,
  input  wire logic       TX_VALID,
  output logic            TX_READY,
  // User receive stream
  output logic            RX_BIT_OUT,
  output logic            RX_VALID,
  output logic            RX_SOF,
  output logic            RX_EOD,
  // User control
  input  wire logic       WAKE_REQ,
  input  wire logic [1:0] MODE_REQ,
  input  wire logic       FAULT_CLEAR,
  // Device fault indications (pins, asynchronous)
  input  wire logic       OVERTEMP_IN,
  input  wire logic       SUPPLY_LOST_IN,
  input  wire logic       GROUND_LOST_IN,
  // Status to user
  output logic            OVERTEMP_FLAG,
  output logic            SUPPLY_LOST_FLAG,
  output logic            GROUND_LOST_FLAG,
  output logic            ARB_LOST,
  output logic            BUS_IDLE,
  // Device pins
  output logic            TXD_PIN,
  output logic            WAKE_PIN,
  output logic            SHAPE_MODE_SELECT_O,
  output logic            SHAPE_MODE_SELECT_OE,
  input  wire logic       RXD_PIN
);
  import vpwc_pkg::*;

  // Pin synchronisers: three stages, change accepted when stages 2 and 3 agree
  logic [2:0] rx_s_r;
  logic [2:0] ot_s_r;
  logic [2:0] sl_s_r;
  logic [2:0] gl_s_r;
  logic       rx_q_r;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rx_s_r <= 3'h0;
      ot_s_r <= 3'h0;
      sl_s_r <= 3'h0;
      gl_s_r <= 3'h0;
    end else if (CE) begin
      rx_s_r <= {rx_s_r[1:0], RXD_PIN};
      ot_s_r <= {ot_s_r[1:0], OVERTEMP_IN};
      sl_s_r <= {sl_s_r[1:0], SUPPLY_LOST_IN};
      gl_s_r <= {gl_s_r[1:0], GROUND_LOST_IN};
    end
  end

  // Filtered receive level; the receiver is always live, asleep or not
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rx_q_r <= 1'b0;
    end else if (CE && (rx_s_r[1] == rx_s_r[2])) begin
      rx_q_r <= rx_s_r[2]; // R1 R2
    end
  end

  // Microsecond tick from a prescaler
  logic [PRESC_W-1:0] presc_r;
  logic               us_tick;
  logic               tx_start;
  assign us_tick = (presc_r == PRESC_W'(TICKS_US - 1));
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      presc_r <= '0; // R19
    end else if (CE) begin
      // Realign at frame start, else the first symbol loses part of a tick
      presc_r <= (us_tick || tx_start) ? '0 : presc_r + 1'b1; // R19
    end
  end

  // Receive pulse timer, restarted on each edge
  logic            rx_prev_r;
  logic            rx_edge;
  logic [US_W-1:0] rx_us_r;
  logic            in_frame_r;
  assign rx_edge = rx_q_r != rx_prev_r;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rx_prev_r <= 1'b0;
      rx_us_r   <= US_ZERO;
    end else if (CE) begin
      rx_prev_r <= rx_q_r;
      if (rx_edge) begin
        rx_us_r <= US_ZERO; // R7
      end else if (us_tick && rx_us_r != {US_W{1'b1}}) begin
        rx_us_r <= rx_us_r + 1'b1; // R19
      end
    end
  end

  // Symbol decoder: level before edge plus width gives bit or SOF; a long low with no edge gives EOD
  logic rx_bit_r, rx_valid_r, rx_sof_r, rx_eod_r;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      in_frame_r <= 1'b0;
      rx_bit_r   <= 1'b0;
      rx_valid_r <= 1'b0;
      rx_sof_r   <= 1'b0;
      rx_eod_r   <= 1'b0;
    end else if (CE) begin
      rx_valid_r <= 1'b0;
      rx_sof_r   <= 1'b0;
      rx_eod_r   <= 1'b0;
      if (rx_edge && rx_prev_r && rx_us_r >= US_W'(SOF_MIN_US)) begin
        in_frame_r <= 1'b1; // R8
        rx_sof_r   <= 1'b1;
      end else if (!rx_q_r && in_frame_r && rx_us_r >= US_W'(SOF_MIN_US)) begin
        in_frame_r <= 1'b0; // R10
        rx_eod_r   <= 1'b1;
      end else if (rx_edge && in_frame_r) begin
        // Low short = 0, low long = 1, high short = 1, high long = 0
        rx_bit_r   <= rx_prev_r ^ (rx_us_r >= US_W'(THRESH_US)); // R9
        rx_valid_r <= 1'b1;
      end
    end
  end
  assign RX_BIT_OUT = rx_bit_r;
  assign RX_VALID   = rx_valid_r;
  assign RX_SOF     = rx_sof_r;
  assign RX_EOD     = rx_eod_r;
  assign BUS_IDLE   = !rx_q_r && rx_us_r >= US_W'(IDLE_MIN_US);

  // Transmit queue decouples the user from symbol timing
  logic [1:0] fq_data;
  logic       fq_valid;
  logic       fq_pop;
  vpwc_fifo #(.WIDTH(2), .DEPTH(FIFO_DEPTH)) u_fifo (
    .CORE_CLK  (CORE_CLK),
    .CE        (CE),
    .RST_N     (RST_N),
    .in_data   ({TX_LAST_IN, TX_BIT_IN}),
    .in_valid  (TX_VALID),
    .in_ready  (TX_READY),
    .out_data  (fq_data),
    .out_valid (fq_valid),
    .out_ready (fq_pop)
  );

  // Fault status flags; hardware set wins over user clear
  logic ot_r, sl_r, gl_r;
  logic ot_ok, sl_ok, gl_ok;
  assign ot_ok = ot_s_r[1] == ot_s_r[2];
  assign sl_ok = sl_s_r[1] == sl_s_r[2];
  assign gl_ok = gl_s_r[1] == gl_s_r[2];
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ot_r <= 1'b0;
      sl_r <= 1'b0;
      gl_r <= 1'b0;
    end else if (CE) begin
      if (ot_ok && ot_s_r[2]) begin
        ot_r <= 1'b1; // R4 R20
      end else if (FAULT_CLEAR && ot_ok) begin
        ot_r <= 1'b0; // R6
      end
      if (sl_ok) begin
        sl_r <= sl_s_r[2]; // R13 R20
      end
      if (gl_ok) begin
        gl_r <= gl_s_r[2]; // R14 R20
      end
    end
  end
  assign OVERTEMP_FLAG    = ot_r;
  assign SUPPLY_LOST_FLAG = sl_r;
  assign GROUND_LOST_FLAG = gl_r;

  // Transmit symbol engine
  vpwc_tx_e        st_r;
  logic [US_W-1:0] sym_us_r;
  logic [US_W-1:0] sym_len_r;
  logic            txd_r;
  logic            last_r;
  logic            arb_r;
  logic            clr_pend_r;
  logic            sym_done;
  logic            faulted;
  logic            stop_now;
  logic            lose_now;
  logic            load_bit;
  assign sym_done = us_tick && (sym_us_r + 1'b1 >= sym_len_r);
  assign faulted  = sl_r || gl_r;
  assign tx_start = (st_r == TX_WAIT) && BUS_IDLE;
  assign stop_now = faulted || ot_r || !WAKE_REQ;
  // Bus high while we are passive: a dominant node outlasted our symbol
  assign lose_now = (st_r == TX_BIT) && !arb_r && !txd_r && rx_q_r && (sym_us_r >= 10'h010);
  // Apart from drops after a lost arbitration, a word leaves the queue exactly when it is loaded into the next symbol
  assign load_bit = ((st_r == TX_SOF) || (st_r == TX_BIT && !last_r)) && sym_done && !arb_r
                    && !stop_now && !lose_now;
  // After a lost arbitration the rest of that message is dropped; a message
  // queued only in part would have its tail sent later as a frame of its own
  assign fq_pop   = load_bit || ((st_r == TX_BIT) && arb_r && !last_r);

  // Symbol width from level and bit; a zero is long high or short low, so zeros win the bus
  function automatic logic [US_W-1:0] sym_len(input logic lvl, input logic b);
    sym_len = (lvl ^ b) ? US_W'(LONG_US) : US_W'(SHORT_US);
  endfunction

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      st_r       <= TX_IDLE;
      sym_us_r   <= US_ZERO; // R19
      sym_len_r  <= US_ZERO;
      txd_r      <= 1'b0;
      last_r     <= 1'b0;
      arb_r      <= 1'b0;
      clr_pend_r <= 1'b0;
    end else if (CE) begin
      sym_us_r <= us_tick ? sym_us_r + 1'b1 : sym_us_r;
      case (st_r)
        TX_IDLE: begin
          txd_r <= 1'b0; // R15
          arb_r <= 1'b0;
          // Overtemp recovery: a low-to-high toggle on transmit data
          if (ot_r && FAULT_CLEAR) begin
            clr_pend_r <= 1'b1; // R5
            txd_r      <= 1'b1; // R5
            st_r       <= TX_RECOVER;
            sym_us_r   <= US_ZERO;
            sym_len_r  <= US_W'(SHORT_US);
          end else if (fq_valid && WAKE_REQ && !ot_r && !faulted) begin
            st_r <= TX_WAIT; // R18
          end
        end
        TX_WAIT: begin
          if (BUS_IDLE) begin
            st_r      <= TX_SOF; // R11
            txd_r     <= 1'b1; // R8
            sym_us_r  <= US_ZERO;
            sym_len_r <= US_W'(SOF_US);
          end else if (!WAKE_REQ || faulted) begin
            st_r <= TX_IDLE;
          end
        end
        TX_SOF, TX_BIT: begin
          // Follow the flag of each word dropped after a lost arbitration
          if (st_r == TX_BIT && arb_r && !last_r && fq_valid) begin
            last_r <= fq_data[1]; // R12
          end
          if (stop_now) begin
            st_r  <= TX_IDLE;
            txd_r <= 1'b0;
          end else if (lose_now) begin
            // Another node kept the bus high: stop sending
            arb_r <= 1'b1; // R12
            txd_r <= 1'b0; // R12
          end else if (sym_done) begin
            if (arb_r) begin
              st_r <= TX_IDLE; // R12
            end else if (st_r == TX_BIT && last_r) begin
              st_r      <= TX_EOD;
              txd_r     <= 1'b0; // R10
              sym_us_r  <= US_ZERO;
              sym_len_r <= US_W'(EOD_US);
            end else begin
              st_r      <= TX_BIT;
              txd_r     <= ~txd_r;
              last_r    <= fq_data[1];
              sym_us_r  <= US_ZERO;
              sym_len_r <= sym_len(~txd_r, fq_data[0]); // R9
            end
          end
        end
        TX_EOD: begin
          if (sym_done) begin
            st_r <= TX_IDLE;
          end
        end
        TX_RECOVER: begin
          if (sym_done) begin
            clr_pend_r <= 1'b0;
            txd_r      <= 1'b0;
            st_r       <= TX_IDLE;
          end
        end
        default: st_r <= TX_IDLE;
      endcase
    end
  end
  assign ARB_LOST = arb_r;
  assign TXD_PIN  = txd_r;

  // Wake and mode pins; never rely on the device waking itself
  logic       wake_r;
  logic [1:0] mode_r;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      wake_r <= 1'b0;
      mode_r <= MODE_SHAPED;
    end else if (CE) begin
      wake_r <= WAKE_REQ && !faulted; // R3 R18
      mode_r <= MODE_REQ; // R16
    end
  end
  assign WAKE_PIN             = wake_r;
  // Loopback leaves the select pin floating; device then keeps off the bus
  assign SHAPE_MODE_SELECT_OE = (mode_r != MODE_LOOP); // R16 R17
  assign SHAPE_MODE_SELECT_O  = (mode_r == MODE_FAST); // R16
endmodule

// ===== tb/vpwc_dev_model.sv
// Behavioural transceiver device seen at the controller pins
`timescale 1ns/1ps
module vpwc_dev (
  // Controller pins
  input  wire logic txd,
  input  wire logic wake,
  input  wire logic sel_oe,
  // Conditions set by the bench
  input  wire logic hot,
  input  wire logic sup_lost,
  input  wire logic gnd_lost,
  input  wire logic node,
  // Receive output and bus level
  output logic      rxd,
  output logic      bus
);
  logic lat = 1'b0;
  logic drv;
  // Hot die latches the driver off; only a rising transmit edge once cool clears it
  always @(posedge hot or posedge txd) begin
    lat <= hot;
  end
  // Drive needs wake and no fault; nothing here ever wakes by itself
  assign drv = txd & wake & sel_oe & !lat & !sup_lost & !gnd_lost;
  // Pull-downs hold the bus low unless a node drives it
  assign bus = drv | node;
  // Receiver never sleeps; loopback echoes transmit and leaves the bus alone
  assign rxd = sel_oe ? bus : txd;
endmodule

// ===== tb/vpwc_ctrl_assertions.sv
// Port-level checker for the VPW link controller
`timescale 1ns/1ps
module vpwc_chk
  import vpwc_pkg::*;
(
  // Clock and reset
  input wire logic       CORE_CLK,
  input wire logic       RST_N,
  // Control and pins
  input wire logic       WAKE_REQ,
  input wire logic       WAKE_PIN,
  input wire logic       TXD_PIN,
  input wire logic [1:0] MODE_REQ,
  input wire logic       SHAPE_MODE_SELECT_O,
  input wire logic       SHAPE_MODE_SELECT_OE,
  // Faults and frame markers
  input wire logic       OVERTEMP_IN,
  input wire logic       OVERTEMP_FLAG,
  input wire logic       SUPPLY_LOST_IN,
  input wire logic       SUPPLY_LOST_FLAG,
  input wire logic       RX_EOD
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // Pins follow requests within a few cycles
  a_wake_drop: assert property ($fell(WAKE_REQ) |-> ##[1:4] !WAKE_PIN)
    else $error("wake pin stuck high");
  a_tx_needs_wake: assert property ($rose(TXD_PIN) |-> WAKE_PIN || OVERTEMP_FLAG)
    else $error("transmit while asleep");
  a_loop_float: assert property ((MODE_REQ == MODE_LOOP) [*2] |-> !SHAPE_MODE_SELECT_OE)
    else $error("loopback pin driven");
  a_fast_high: assert property ((MODE_REQ == MODE_FAST) [*2] |->
    SHAPE_MODE_SELECT_OE && SHAPE_MODE_SELECT_O)
    else $error("fast mode pin wrong");
  a_shaped_low: assert property ((MODE_REQ == MODE_SHAPED) [*2] |->
    SHAPE_MODE_SELECT_OE && !SHAPE_MODE_SELECT_O)
    else $error("shaped mode pin wrong");
  // The overtemperature flag sets soon and holds while the fault lasts
  a_ot_latch: assert property ($rose(OVERTEMP_IN) |-> ##[1:8] OVERTEMP_FLAG)
    else $error("overtemp flag missed");
  a_ot_hold: assert property (OVERTEMP_FLAG && OVERTEMP_IN |=> OVERTEMP_FLAG)
    else $error("overtemp flag dropped");
  a_sup_flag: assert property ($rose(SUPPLY_LOST_IN) |-> ##[1:64] SUPPLY_LOST_FLAG)
    else $error("supply flag missed");
  // Main scenarios reached
  c_eod: cover property (RX_EOD);
  c_ot_clear: cover property ($fell(OVERTEMP_FLAG));
  c_loop: cover property (MODE_REQ == MODE_LOOP && !SHAPE_MODE_SELECT_OE);
endmodule
bind vpwc_ctrl vpwc_chk u_chk (.*);

// ===== tb/tb_vpwc_ctrl.sv
// Self-checking bench for the VPW link controller
`timescale 1ns/1ps
module tb_vpwc_ctrl;
  import vpwc_pkg::*;
  localparam int T = 4; // Ticks per microsecond, shortened for run time
  logic CORE_CLK = 1'b0, RST_N = 1'b0, CE = 1'b1, RXD_PIN, node = 1'b0, bus;
  logic TX_BIT_IN = 1'b0, TX_LAST_IN = 1'b0, TX_VALID = 1'b0, TX_READY;
  logic WAKE_REQ = 1'b0, FAULT_CLEAR = 1'b0, hi_seen = 1'b0;
  logic [1:0] MODE_REQ = MODE_SHAPED;
  logic OVERTEMP_IN = 1'b0, SUPPLY_LOST_IN = 1'b0, GROUND_LOST_IN = 1'b0;
  logic RX_BIT_OUT, RX_VALID, RX_SOF, RX_EOD, OVERTEMP_FLAG, SUPPLY_LOST_FLAG;
  logic GROUND_LOST_FLAG, ARB_LOST, BUS_IDLE, TXD_PIN, WAKE_PIN;
  logic SHAPE_MODE_SELECT_O, SHAPE_MODE_SELECT_OE;
  int fails = 0, checks = 0, sofs = 0, eods = 0, cyc = 0, t0 = 0;
  logic rxq[$];
  int wid[$];
  vpwc_ctrl #(.TICKS_US(T)) DUT (.*);
  vpwc_dev dev (.txd(TXD_PIN), .wake(WAKE_PIN), .sel_oe(SHAPE_MODE_SELECT_OE),
    .hot(OVERTEMP_IN), .sup_lost(SUPPLY_LOST_IN), .gnd_lost(GROUND_LOST_IN),
    .node(node), .rxd(RXD_PIN), .bus(bus));
  always #4 CORE_CLK = ~CORE_CLK;
  // Gather decoded bits, frame markers and any bus drive
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (RX_VALID === 1'b1) rxq.push_back(RX_BIT_OUT);
    if (RX_SOF === 1'b1) sofs <= sofs + 1;
    if (RX_EOD === 1'b1) eods <= eods + 1;
    if (bus === 1'b1) hi_seen <= 1'b1;
  end
  // Transmit pulse widths; edge order against the counter may slip one cycle
  always @(TXD_PIN) begin
    wid.push_back(cyc - t0);
    t0 = cyc;
  end
  task automatic chk(input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic chkn(input int e, input int g, input int tol);
    checks++;
    if (g < e - tol || g > e + tol) begin
      fails++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask
  task automatic hold(input logic lv, input int us);
    node = lv;
    ticks(us * T);
  endtask
  // Far node sends a frame; long symbol when level and bit differ
  task automatic node_msg(input logic [7:0] v);
    logic lv;
    lv = 1'b0;
    hold(1'b1, SOF_US);
    for (int i = 7; i >= 0; i--) begin
      hold(lv, (lv ^ v[i]) ? LONG_US : SHORT_US);
      lv = !lv;
    end
    hold(1'b0, EOD_US);
  endtask
  // Queue one message, one bit per word, holding valid until taken
  task automatic send(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      TX_BIT_IN = v[i];
      TX_LAST_IN = (i == 0);
      TX_VALID = 1'b1;
      @(posedge CORE_CLK);
      while (TX_READY !== 1'b1) @(posedge CORE_CLK);
      @(negedge CORE_CLK);
    end
    TX_VALID = 1'b0;
  endtask
  task automatic frame_end(input int n, input logic [7:0] v);
    for (int i = 0; i < 40000 && eods < n; i++) ticks(1);
    chkn(n, eods, 0);
    chkn(8, rxq.size(), 0);
    for (int i = 0; i < 8 && i < rxq.size(); i++) chk(v[7 - i], rxq[i]);
    rxq = {};
  endtask
  task automatic clr;
    FAULT_CLEAR = 1'b1;
    ticks(1);
    FAULT_CLEAR = 1'b0;
    // Let a recovery toggle finish before the next request
    ticks(SHORT_US * T + 20);
  endtask
  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Expected run is about 21600 cycles
  initial begin
    ticks(60000);
    fails++;
    complete_run;
  end
  initial begin
    ticks(4);
    RST_N = 1'b1;
    ticks(1);
    chk(1'b1, TX_READY);
    chk(1'b0, OVERTEMP_FLAG);
    ticks(300 * T);
    node_msg(8'ha5);
    frame_end(1, 8'ha5);
    chkn(1, sofs, 0);
    chk(1'b0, WAKE_PIN);
    ticks(IDLE_MIN_US * T);
    chk(1'b1, BUS_IDLE);
    // Awake, shaped: own frame on the wire and echoed back
    WAKE_REQ = 1'b1;
    wid = {};
    send(8'h3c);
    frame_end(2, 8'h3c);
    chkn(SOF_US * T, wid[1], 2);
    for (int i = 0; i < 8; i++) begin
      chkn(((i % 2 == 1) ^ (8'h3c >> (7 - i)) & 1) ? LONG_US * T : SHORT_US * T,
        wid[i + 2], 2);
    end
    MODE_REQ = MODE_LOOP;
    ticks(IDLE_MIN_US * T);
    chk(1'b0, SHAPE_MODE_SELECT_OE);
    hi_seen = 1'b0;
    send(8'h96);
    frame_end(3, 8'h96);
    chk(1'b0, hi_seen);
    MODE_REQ = MODE_FAST;
    ticks(4);
    chk(1'b1, SHAPE_MODE_SELECT_O);
    MODE_REQ = MODE_SHAPED;
    // Far node holds the bus high for 40 us into our first passive symbol
    send(8'hff);
    wait (TXD_PIN === 1'b1);
    wait (TXD_PIN === 1'b0);
    ticks(1);
    hold(1'b1, 40);
    chk(1'b1, ARB_LOST);
    hold(1'b0, 200);
    chk(1'b0, ARB_LOST);
    // Rest of the lost message must not come back as a new frame
    ticks(IDLE_MIN_US * T);
    chk(1'b0, TXD_PIN);
    OVERTEMP_IN = 1'b1;
    ticks(10);
    chk(1'b1, OVERTEMP_FLAG);
    clr();
    chk(1'b1, OVERTEMP_FLAG);
    OVERTEMP_IN = 1'b0;
    ticks(10);
    clr();
    ticks(SHORT_US * T);
    chk(1'b0, OVERTEMP_FLAG);
    chk(1'b0, dev.lat);
    SUPPLY_LOST_IN = 1'b1;
    ticks(100);
    chk(1'b1, SUPPLY_LOST_FLAG);
    SUPPLY_LOST_IN = 1'b0;
    GROUND_LOST_IN = 1'b1;
    ticks(100);
    chk(1'b0, SUPPLY_LOST_FLAG);
    chk(1'b1, GROUND_LOST_FLAG);
    GROUND_LOST_IN = 1'b0;
    WAKE_REQ = 1'b0;
    ticks(4);
    chk(1'b0, WAKE_PIN);
    complete_run;
  end
endmodule
